// File: hdl/csxd_pkg.sv
/*
 * Constants for the compare, test-zero and literal-xor decode/execute block.
 * Assumes one instruction clock in which each instruction cycle takes four phases.
 */
package csxd_pkg;
	localparam logic [6:0] CSXD_OP_SKIP_GREATER = 7'h32;
	localparam logic [6:0] CSXD_OP_SKIP_LESS    = 7'h30;
	localparam logic [6:0] CSXD_OP_SKIP_ZERO    = 7'h33;
	localparam logic [7:0] CSXD_OP_XOR_LITERAL  = 8'h0A;
	localparam logic [7:0] CSXD_INDEXED_LIMIT   = 8'h5F;
	localparam logic [7:0] CSXD_ACCESS_SPLIT    = 8'h60;
	localparam int         CSXD_BANK_BITS       = 4;
	localparam logic [7:0] CSXD_WORK_RESET      = 8'h00;
	localparam logic [3:0] CSXD_BANK_RESET      = 4'h0;
	localparam logic [3:0] CSXD_ACCESS_HIGH     = 4'hF;
	localparam logic [1:0] CSXD_PHASE_RESET     = 2'h0;
	localparam logic [1:0] CSXD_PHASE_LAST      = 2'h3;
	localparam logic [1:0] CSXD_NOP_ONE_WORD    = 2'h1;
	localparam logic [1:0] CSXD_NOP_TWO_WORD    = 2'h2;
	typedef enum logic [1:0] {CSXD_PH_DECODE, CSXD_PH_READ, CSXD_PH_PROCESS, CSXD_PH_WRITE}
		csxd_phase_e;
endpackage

// File: hdl/csxd_alu.sv
/*
 * Combinational evaluator: unsigned compare by subtraction, zero test and xor.
 * Assumes operands are stable during the write phase, when the core uses the results.
 */
`timescale 1ns/1ns
`default_nettype none
module csxd_alu
	import csxd_pkg::*;
(
	input  wire logic [7:0] file_val_i,
	input  wire logic [7:0] work_val_i,
	input  wire logic [7:0] literal_i,
	output logic            greater_o,
	output logic            less_o,
	output logic            zero_o,
	output logic [7:0]      xor_o
);
	wire logic [8:0] diff;
	wire logic [8:0] diff_rev;

	// Unsigned f - W; borrow means f < W, the reverse borrow means f > W.
	assign diff      = {1'b0, file_val_i} - {1'b0, work_val_i};
	assign diff_rev  = {1'b0, work_val_i} - {1'b0, file_val_i};
	assign less_o    = diff[8];
	assign greater_o = diff_rev[8];
	assign zero_o    = (file_val_i == 8'h00);
	assign xor_o     = work_val_i ^ literal_i;
endmodule
`default_nettype wire

// File: hdl/csxd_core.sv
/*
 * Decode and execute of compare-skip-greater, compare-skip-less, test-skip-zero and
 * xor-literal-to-work. Holds the working register and its negative and zero flags.
 * Assumes the fetch unit presents the instruction word at phase zero of each cycle and
 * that the data memory answers a read address with data in the same cycle.
 */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Opcode 0110010a with file address skips the next instruction when file exceeds work.
// - Opcode 0110000a with file address skips the next instruction when file is below work.
// - Opcode 0110011a with file address skips the next instruction when the file byte is zero.
// - A taken skip discards the prefetched word and runs one no-operation cycle instead, two when the next instruction is two words.
// - Less subtracts work from file, greater subtracts file from work, both unsigned; neither modifies a register.
// - Bank bit clear addresses the access bank; set, the bank select register gives the bank.
// - Bank bit clear, extended set enabled and address at most 5Fh use indexed literal offset.
// - Any file address 0 to 255 and either bank bit value are accepted as operands.
// - Opcode 00001010 xors the literal into the working register and updates negative and zero.
module csxd_core
	import csxd_pkg::*;
(
	input  wire logic                      mclk_i,
	input  wire logic                      sys_rst_i,
	input  wire logic [15:0]               instr_i,
	input  wire logic                      next_two_word_i,
	input  wire logic                      ext_set_en_i,
	input  wire logic [CSXD_BANK_BITS-1:0] bank_select_register_i,
	input  wire logic [7:0]                index_base_i,
	input  wire logic [7:0]                file_data_i,
	output logic [11:0]                    file_addr_o,
	output logic                           file_rd_o,
	output logic [7:0]                     working_register_o,
	output logic                           neg_flag_o,
	output logic                           zero_flag_o,
	output logic                           skip_o,
	output logic                           nop_cycle_o,
	output logic [1:0]                     phase_o
);
	csxd_phase_e phase;
	csxd_phase_e next_phase;
	logic [15:0] ir;
	logic [7:0]  working_register;
	logic [7:0]  file_val;
	logic [1:0]  nop_left;
	logic        nop_cycle;
	logic        neg_flag;
	logic        zero_flag;
	logic        skip;
	logic [11:0] file_addr;
	logic        file_rd;

	wire logic       is_greater;
	wire logic       is_less;
	wire logic       is_zero_test;
	wire logic       is_xor;
	wire logic       is_file_op;
	wire logic       bank_bit;
	wire logic [7:0] faddr;
	wire logic       indexed;
	wire logic [7:0] indexed_addr;
	wire logic [11:0] next_file_addr;
	wire logic       alu_greater;
	wire logic       alu_less;
	wire logic       alu_zero;
	wire logic [7:0] alu_xor;
	wire logic       skip_taken;
	wire logic       in_nop;
	wire logic [1:0] skip_nop_count;
	wire logic [1:0] next_nop_left;
	wire logic       next_skip;
	wire logic       at_decode;
	wire logic       at_read;
	wire logic       at_process;
	wire logic       at_write;
	wire logic [15:0] next_ir;
	wire logic       write_work;
	wire logic       next_neg_flag;
	wire logic       next_zero_flag;

	assign is_greater   = (ir[15:9] == CSXD_OP_SKIP_GREATER);
	assign is_less      = (ir[15:9] == CSXD_OP_SKIP_LESS);
	assign is_zero_test = (ir[15:9] == CSXD_OP_SKIP_ZERO);
	assign is_xor       = (ir[15:8] == CSXD_OP_XOR_LITERAL);
	assign is_file_op   = is_greater | is_less | is_zero_test;
	assign bank_bit     = ir[8];
	assign faddr        = ir[7:0];
	assign indexed      = !bank_bit && ext_set_en_i && (faddr <= CSXD_INDEXED_LIMIT);
	assign indexed_addr = index_base_i + faddr;
	// Access bank: low addresses map to bank 0, the rest to the top bank.
	assign next_file_addr = indexed ? {4'h0, indexed_addr}
		: bank_bit ? {bank_select_register_i, faddr}
		: (faddr < CSXD_ACCESS_SPLIT) ? {4'h0, faddr} : {CSXD_ACCESS_HIGH, faddr};
	// Indexed offset here ignores a carry past 8 bits; the upper page is not reachable.

	csxd_alu u_alu (
		.file_val_i (file_val),
		.work_val_i (working_register),
		.literal_i  (ir[7:0]),
		.greater_o  (alu_greater),
		.less_o     (alu_less),
		.zero_o     (alu_zero),
		.xor_o      (alu_xor)
	);

	assign skip_taken = (is_greater && alu_greater) || (is_less && alu_less)
		|| (is_zero_test && alu_zero);
	assign in_nop = (nop_left != 2'h0);
	assign skip_nop_count = next_two_word_i ? CSXD_NOP_TWO_WORD : CSXD_NOP_ONE_WORD;
	// A countdown in progress wins over a new skip: a discarded word cannot skip again.
	assign next_nop_left = in_nop ? (nop_left - 2'h1)
		: skip_taken ? skip_nop_count : 2'h0;
	assign next_skip = !in_nop && skip_taken;

	assign at_decode  = (phase == CSXD_PH_DECODE);
	assign at_read    = (phase == CSXD_PH_READ);
	assign at_process = (phase == CSXD_PH_PROCESS);
	assign at_write   = (phase == CSXD_PH_WRITE);

	// A discarded word is latched as zero, which decodes to nothing.
	assign next_ir = in_nop ? 16'h0000 : instr_i;
	// Only xor writes work and flags; compares leave both untouched.
	assign write_work     = at_write && is_xor;
	assign next_neg_flag  = alu_xor[7];
	assign next_zero_flag = (alu_xor == 8'h00);

	always_comb
	begin
		case (phase)
			CSXD_PH_DECODE:  next_phase = CSXD_PH_READ;
			CSXD_PH_READ:    next_phase = CSXD_PH_PROCESS;
			CSXD_PH_PROCESS: next_phase = CSXD_PH_WRITE;
			CSXD_PH_WRITE:   next_phase = CSXD_PH_DECODE;
			default:         next_phase = CSXD_PH_DECODE;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			phase <= CSXD_PH_DECODE;
		else
			phase <= next_phase;
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			ir <= 16'h0000;
		else if (at_decode)
			ir <= next_ir;
	end

	// The address is held until the next read phase so the memory sees a steady request.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			file_addr <= 12'h000;
			file_rd <= 1'b0;
		end
		else
		begin
			if (at_read)
				file_addr <= next_file_addr;
			file_rd <= at_read && is_file_op;
		end
	end

	// Data is captured while the read strobe stands, one cycle after the address moved.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			file_val <= 8'h00;
		else if (at_process)
			file_val <= file_data_i;
	end

	// The discard count and its output copy change together, at the end of the write phase.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			nop_left <= 2'h0;
			nop_cycle <= 1'b0;
			skip <= 1'b0;
		end
		else
		begin
			if (at_write)
			begin
				nop_left <= next_nop_left;
				nop_cycle <= (next_nop_left != 2'h0);
			end
			skip <= at_write && next_skip;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			working_register <= CSXD_WORK_RESET;
			neg_flag <= 1'b0;
			zero_flag <= 1'b0;
		end
		else if (write_work)
		begin
			working_register <= alu_xor;
			neg_flag <= next_neg_flag;
			zero_flag <= next_zero_flag;
		end
	end

	assign working_register_o = working_register;
	assign neg_flag_o = neg_flag;
	assign zero_flag_o = zero_flag;
	assign skip_o = skip;
	assign file_addr_o = file_addr;
	assign file_rd_o = file_rd;
	assign phase_o = phase;
	assign nop_cycle_o = nop_cycle;
endmodule
`default_nettype wire

// File: dv/csxd_asserts.sv
/*
 * Port-level checker for the compare, test-zero and xor block.
 * Assumes it is bound to csxd_core and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
module csxd_asserts
(
	input wire logic        mclk_i,
	input wire logic        sys_rst_i,
	input wire logic [11:0] file_addr_o,
	input wire logic        file_rd_o,
	input wire logic [7:0]  working_register_o,
	input wire logic        neg_flag_o,
	input wire logic        zero_flag_o,
	input wire logic        skip_o,
	input wire logic        nop_cycle_o,
	input wire logic [1:0]  phase_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	chk_phase_step: assert property (!$past(sys_rst_i) |->
		phase_o == $past(phase_o) + 2'h1) else $error("phase did not advance");
	chk_read_phase: assert property (file_rd_o |-> phase_o == 2'h2)
		else $error("read strobe outside phase 2");
	chk_addr_phase: assert property (!$past(sys_rst_i) && $changed(file_addr_o)
		|-> phase_o == 2'h2) else $error("address moved outside phase 2");
	chk_skip_nop: assert property (skip_o |-> nop_cycle_o && phase_o == 2'h0)
		else $error("skip without discarded cycle");
	chk_nop_length: assert property ($rose(nop_cycle_o) |->
		(skip_o && nop_cycle_o) ##1 nop_cycle_o[*3])
		else $error("discarded cycle shorter than four phases");
	chk_skip_flags: assert property (skip_o |->
		$stable(neg_flag_o) && $stable(zero_flag_o)) else $error("skip changed a flag");
	chk_work_phase: assert property (!$past(sys_rst_i) && $changed(working_register_o)
		|-> phase_o == 2'h0) else $error("work register moved off phase 0");
	chk_zero_flag: assert property (!$past(sys_rst_i) && $changed(working_register_o)
		|-> zero_flag_o == (working_register_o == 8'h00)) else $error("zero flag wrong");
	chk_neg_flag: assert property (!$past(sys_rst_i) && $changed(working_register_o)
		|-> neg_flag_o == working_register_o[7]) else $error("negative flag wrong");
	cover property (skip_o);
	cover property ($rose(nop_cycle_o) ##4 nop_cycle_o);
	cover property ($changed(working_register_o) && zero_flag_o);
endmodule
bind csxd_core csxd_asserts u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
	.file_addr_o(file_addr_o), .file_rd_o(file_rd_o), .working_register_o(working_register_o),
	.neg_flag_o(neg_flag_o), .zero_flag_o(zero_flag_o), .skip_o(skip_o),
	.nop_cycle_o(nop_cycle_o), .phase_o(phase_o));
`default_nettype wire

// File: dv/testbench.sv
/*
 * Self-checking bench for csxd_core.
 * Assumes the package and design are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	typedef struct packed {logic [15:0] ins; logic [7:0] d; logic e; logic sk;
		logic [11:0] a;} csxd_row_s;
	logic        mclk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [15:0] instr_i = 16'h0000;
	logic        two_w = 1'b0;
	logic        ext = 1'b0;
	logic [7:0]  data = 8'h00;
	logic [11:0] addr_o;
	logic [11:0] got_addr;
	logic [7:0]  w_o;
	logic        neg_o;
	logic        zf_o;
	logic        nop_o;
	logic [11:0] wst;
	int          num_errors = 0;
	int          comparisons = 0;
	int          nops = 0;
	int          cyc = 0;
	csxd_row_s   rows [6] = '{'{16'h6420, 8'h1B, 1'b0, 1'b1, 12'h020},
		'{16'h6530, 8'h1A, 1'b0, 1'b0, 12'h530}, '{16'h6070, 8'h19, 1'b0, 1'b1, 12'hF70},
		'{16'h61FF, 8'hFF, 1'b0, 1'b0, 12'h5FF}, '{16'h665F, 8'h00, 1'b1, 1'b1, 12'h06F},
		'{16'h6660, 8'h01, 1'b1, 1'b0, 12'hF60}};
	assign wst = {2'b00, neg_o, zf_o, w_o};
	csxd_core uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i),
		.next_two_word_i(two_w), .ext_set_en_i(ext), .bank_select_register_i(4'h5),
		.index_base_i(8'h10), .file_data_i(data), .file_addr_o(addr_o), .file_rd_o(),
		.working_register_o(w_o), .neg_flag_o(neg_o), .zero_flag_o(zf_o), .skip_o(),
		.nop_cycle_o(nop_o), .phase_o());
	always #20 mclk_i = ~mclk_i;
	always @(negedge mclk_i) nops += int'(nop_o === 1'b1);
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			num_errors++;
			finish_test();
		end
	end
	task chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// The filler slot lets a discarded cycle finish before the next word.
	task run(input logic [15:0] ins, input logic [7:0] d, input int slots);
		instr_i = ins;
		data = d;
		nops = 0;
		repeat (3) @(negedge mclk_i);
		got_addr = addr_o;
		@(negedge mclk_i);
		instr_i = 16'h0000;
		repeat (4 * slots) @(negedge mclk_i);
		$display("test %h done", ins);
	endtask
	task finish_test;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		run(16'h0AB5, 8'h00, 1);
		run(16'h0AAF, 8'h00, 1);
		chk("work", 12'h01A, wst);
		foreach (rows[i])
		begin
			ext = rows[i].e;
			run(rows[i].ins, rows[i].d, 1);
			chk("addr", rows[i].a, got_addr);
			chk("nops", rows[i].sk ? 12'h004 : 12'h000, 12'(nops));
		end
		chk("work", 12'h01A, wst);
		ext = 1'b0;
		two_w = 1'b1;
		run(16'h6420, 8'hFF, 2);
		chk("nops", 12'h008, 12'(nops));
		two_w = 1'b0;
		run(16'h0A1A, 8'h00, 1);
		chk("work", 12'h100, wst);
		run(16'h6600, 8'h00, 1);
		chk("nops", 12'h004, 12'(nops));
		chk("work", 12'h100, wst);
		run(16'h0A80, 8'h00, 1);
		chk("work", 12'h280, wst);
		sys_rst_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		chk("reset", 12'h000, wst | addr_o);
		sys_rst_i = 1'b0;
		run(16'h0A5A, 8'h00, 1);
		chk("work", 12'h05A, wst);
		finish_test();
	end
endmodule
`default_nettype wire
